// ---- hdl/udpair_pkg.sv ----
// Package for the USB device address and interrupt register slice.
// Assumes a 32-bit APB slave; offsets are byte addresses.
package udpair_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] UDPAIR_OFF_FADDR = 8'h08;
  localparam logic [7:0] UDPAIR_OFF_IEN_SET = 8'h10;
  localparam logic [7:0] UDPAIR_OFF_IEN_CLR = 8'h14;
  localparam logic [7:0] UDPAIR_OFF_IEN_STATE = 8'h18;
  localparam logic [7:0] UDPAIR_OFF_IRQ_PEND = 8'h1C;
  localparam logic [7:0] UDPAIR_OFF_IRQ_CLR = 8'h20;
  localparam logic [7:0] UDPAIR_OFF_BUS_CTRL = 8'h24;

  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int UDPAIR_NUM_EP = 4;
  localparam int UDPAIR_FADDR_W = 7;
  localparam int UDPAIR_FUNC_EN_BIT = 8;
  localparam int UDPAIR_SUSP_BIT = 8;
  localparam int UDPAIR_RSM_BIT = 9;
  localparam int UDPAIR_EXT_RESUME_BIT = 10;
  localparam int UDPAIR_SOF_BIT = 11;
  localparam int UDPAIR_BUSRES_BIT = 12;
  localparam int UDPAIR_WAKE_BIT = 13;
  localparam int UDPAIR_IRQ_W = 14;
  localparam int UDPAIR_EP_CAUSES = 5;

  // Maskable bits: endpoints 3:0, bus sources 11:8 and 13
  localparam logic [UDPAIR_IRQ_W-1:0] UDPAIR_MASKABLE = 14'h2F0F;
  // Bits that software may clear through the clear register
  localparam logic [UDPAIR_IRQ_W-1:0] UDPAIR_CLEARABLE = 14'h3F00;
  localparam logic [UDPAIR_IRQ_W-1:0] UDPAIR_MASK_RESET = 14'h0200;
  localparam logic [UDPAIR_FADDR_W-1:0] UDPAIR_FADDR_RESET = 7'h00;
  localparam logic UDPAIR_FUNC_EN_RESET = 1'b0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int UDPAIR_CLK_MHZ = 100;
  localparam int UDPAIR_IDLE_SUSP_US = 3000;
  localparam int UDPAIR_IDLE_SUSP_CYC = UDPAIR_IDLE_SUSP_US * UDPAIR_CLK_MHZ;
  localparam int UDPAIR_IDLE_CNT_W = 19;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic setup_received;
    logic bank0_rx_ready;
    logic bank1_rx_ready;
    logic tx_complete;
    logic stall_handshake_sent;
  } udpair_ep_flags_t;

  typedef struct packed {
    logic bus_activity;
    logic resume_seen;
    logic ext_resume_edge;
    logic frame_start;
    logic bus_reset_done;
    logic bus_wake;
  } udpair_bus_evt_t;

  typedef enum logic [1:0] {
    UDPAIR_ACTIVE = 2'b01,
    UDPAIR_SUSPENDED = 2'b10
  } udpair_pwr_t;

endpackage

// ---- hdl/udpair_regs.sv ----
// APB register slice: function address, function enable, interrupt
// enable/mask/status for four endpoints and the bus-level sources.
// Assumes endpoint cause flags are held in the endpoint control/status
// logic elsewhere and bus events arrive as one-cycle pulses on pclk.

`timescale 1ns/10ps

module udpair_regs
  import udpair_pkg::*;
#(
  parameter int IDLE_SUSP_CYC = UDPAIR_IDLE_SUSP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire udpair_ep_flags_t [UDPAIR_NUM_EP-1:0] ep_flags,
  input wire udpair_bus_evt_t bus_evt,
  output logic [UDPAIR_FADDR_W-1:0] function_address_value,
  output logic function_enable,
  output logic ep_xfer_allow,
  output logic suspended,
  output logic irq
);

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
    hit = (a[31:8] == 24'h000000) && (a[7:0] == off);
  endfunction

  logic wr_en;
  logic rd_en;
  logic mapped;

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign mapped = hit(paddr, UDPAIR_OFF_FADDR) | hit(paddr, UDPAIR_OFF_IEN_SET)
                | hit(paddr, UDPAIR_OFF_IEN_CLR) | hit(paddr, UDPAIR_OFF_IEN_STATE)
                | hit(paddr, UDPAIR_OFF_IRQ_PEND) | hit(paddr, UDPAIR_OFF_IRQ_CLR)
                | hit(paddr, UDPAIR_OFF_BUS_CTRL);
  // Unmapped access answers with an error so firmware mistakes show up
  assign pslverr = psel & penable & ~mapped;

  // ----------------------------------------
  // Function address and enable
  // ----------------------------------------
  logic [UDPAIR_FADDR_W-1:0] faddr_q;
  logic [UDPAIR_FADDR_W-1:0] faddr_d;
  logic func_en_q;
  logic func_en_d;

  always_comb begin
    faddr_d = faddr_q;
    func_en_d = func_en_q;
    if (wr_en && hit(paddr, UDPAIR_OFF_FADDR)) begin
      // Load ordering after set-address is firmware's duty
      faddr_d = pwdata[UDPAIR_FADDR_W-1:0];
      func_en_d = pwdata[UDPAIR_FUNC_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      faddr_q <= UDPAIR_FADDR_RESET;
      func_en_q <= UDPAIR_FUNC_EN_RESET;
    end else begin
      faddr_q <= faddr_d;
      func_en_q <= func_en_d;
    end
  end

  assign function_address_value = faddr_q;
  assign function_enable = func_en_q;
  assign ep_xfer_allow = func_en_q;

  // ----------------------------------------
  // Interrupt mask
  // ----------------------------------------
  logic [UDPAIR_IRQ_W-1:0] mask_q;
  logic [UDPAIR_IRQ_W-1:0] mask_d;

  always_comb begin
    mask_d = mask_q;
    if (wr_en && hit(paddr, UDPAIR_OFF_IEN_SET)) begin
      mask_d = mask_q | (pwdata[UDPAIR_IRQ_W-1:0] & UDPAIR_MASKABLE);
    end
    if (wr_en && hit(paddr, UDPAIR_OFF_IEN_CLR)) begin
      mask_d = mask_q & ~(pwdata[UDPAIR_IRQ_W-1:0] & UDPAIR_MASKABLE);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Resume stays visible even if USB logic is powered down in suspend
      mask_q <= UDPAIR_MASK_RESET;
    end else begin
      mask_q <= mask_d;
    end
  end

  // ----------------------------------------
  // Endpoint pending: direct from cause flags
  // ----------------------------------------
  logic [UDPAIR_NUM_EP-1:0] ep_pend;

  // Sticky by construction: clears only when the endpoint flags clear
  generate
    for (genvar e = 0; e < UDPAIR_NUM_EP; e++) begin : g_ep
      assign ep_pend[e] = |ep_flags[e];
    end
  endgenerate

  // ----------------------------------------
  // Suspend detection
  // ----------------------------------------
  udpair_pwr_t pwr_q;
  udpair_pwr_t pwr_d;
  logic [UDPAIR_IDLE_CNT_W-1:0] idle_q;
  logic [UDPAIR_IDLE_CNT_W-1:0] idle_d;
  logic susp_evt;

  always_comb begin
    pwr_d = pwr_q;
    idle_d = idle_q;
    susp_evt = 1'b0;
    case (pwr_q)
      UDPAIR_ACTIVE: begin
        if (bus_evt.bus_activity) begin
          idle_d = '0;
        end else if (idle_q == IDLE_SUSP_CYC[UDPAIR_IDLE_CNT_W-1:0] - 1'b1) begin
          susp_evt = 1'b1;
          pwr_d = UDPAIR_SUSPENDED;
          idle_d = '0;
        end else begin
          idle_d = idle_q + 1'b1;
        end
      end
      UDPAIR_SUSPENDED: begin
        idle_d = '0;
        if (bus_evt.bus_activity) begin
          pwr_d = UDPAIR_ACTIVE;
        end
      end
      default: begin
        pwr_d = UDPAIR_ACTIVE;
        idle_d = '0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_q <= UDPAIR_ACTIVE;
      idle_q <= '0;
    end else begin
      pwr_q <= pwr_d;
      idle_q <= idle_d;
    end
  end

  assign suspended = (pwr_q == UDPAIR_SUSPENDED);

  // ----------------------------------------
  // Bus-level sticky status
  // ----------------------------------------
  logic [UDPAIR_IRQ_W-1:0] bstat_q;
  logic [UDPAIR_IRQ_W-1:0] bstat_d;
  logic [UDPAIR_IRQ_W-1:0] bset;
  logic [UDPAIR_IRQ_W-1:0] bclr;

  always_comb begin
    bset = '0;
    bset[UDPAIR_SUSP_BIT] = susp_evt;
    bset[UDPAIR_RSM_BIT] = bus_evt.resume_seen;
    bset[UDPAIR_EXT_RESUME_BIT] = bus_evt.ext_resume_edge & suspended;
    bset[UDPAIR_SOF_BIT] = bus_evt.frame_start;
    bset[UDPAIR_BUSRES_BIT] = bus_evt.bus_reset_done;
    bset[UDPAIR_WAKE_BIT] = bus_evt.bus_wake;
    bclr = '0;
    if (wr_en && hit(paddr, UDPAIR_OFF_IRQ_CLR)) begin
      bclr = pwdata[UDPAIR_IRQ_W-1:0] & UDPAIR_CLEARABLE;
    end
    // Set wins over a clear in the same cycle
    bstat_d = (bstat_q & ~bclr) | bset;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bstat_q <= '0;
    end else begin
      bstat_q <= bstat_d;
    end
  end

  logic [UDPAIR_IRQ_W-1:0] status;

  assign status = {bstat_q[UDPAIR_IRQ_W-1:UDPAIR_NUM_EP], ep_pend};

  // ----------------------------------------
  // Interrupt output
  // ----------------------------------------
  // Bus-reset-done has no mask bit, so it never drives the line
  assign irq = |(status & mask_q & UDPAIR_MASKABLE);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;

  always_comb begin
    rdata_d = rdata_q;
    if (rd_en) begin
      rdata_d = '0;
      if (hit(paddr, UDPAIR_OFF_FADDR)) begin
        rdata_d[UDPAIR_FADDR_W-1:0] = faddr_q;
        rdata_d[UDPAIR_FUNC_EN_BIT] = func_en_q;
      end
      if (hit(paddr, UDPAIR_OFF_IEN_STATE)) begin
        rdata_d[UDPAIR_IRQ_W-1:0] = mask_q;
      end
      if (hit(paddr, UDPAIR_OFF_IRQ_PEND)) begin
        rdata_d[UDPAIR_IRQ_W-1:0] = status;
      end
      if (hit(paddr, UDPAIR_OFF_BUS_CTRL)) begin
        rdata_d[0] = suspended;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Registered data is taken at the access edge, so drive it combinationally
  // from the decode during the access phase and hold the last value otherwise
  assign prdata = rd_en ? rdata_d : rdata_q;

endmodule // udpair_regs

// ---- test/udpair_host_model.sv ----
// Host-side bus event source for the udpair bench.
// Bench calls pulse() just after a clock edge; quiet idles the bus.
`timescale 1ns/10ps
module udpair_host_model
  import udpair_pkg::*;
(
  input wire logic pclk,
  input wire logic quiet,
  output udpair_bus_evt_t bus_evt
);
  initial bus_evt = '0;
  // Silence on the bus is what lets the device fall asleep
  always @(posedge pclk) bus_evt.bus_activity <= !quiet;
  // One-cycle strobe; k counts fields from bus_wake upward
  task automatic pulse(input int k);
    @(posedge pclk);
    bus_evt[k] <= 1'b1;
    @(posedge pclk);
    bus_evt[k] <= 1'b0;
  endtask
endmodule // udpair_host_model

// ---- test/udpair_regs_assertions.sv ----
// Port-level checker for udpair_regs.
// Bound from the bench top; sees only the slice's ports.
`timescale 1ns/10ps
module udpair_regs_assertions
  import udpair_pkg::*;
#(parameter int IDLE_SUSP_CYC = 20) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire udpair_ep_flags_t [UDPAIR_NUM_EP-1:0] ep_flags,
  input wire udpair_bus_evt_t bus_evt,
  input wire logic [UDPAIR_FADDR_W-1:0] function_address_value,
  input wire logic function_enable,
  input wire logic ep_xfer_allow,
  input wire logic suspended,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Shadow mask and idle count
  // ----------------------------------------
  logic [13:0] msk_q, msk_d;
  logic [3:0] ep_or;
  int idle_q, idle_d;
  function automatic logic hit(logic [7:0] a);
    return psel && penable && paddr == {24'h0, a};
  endfunction
  always_comb begin
    for (int e = 0; e < 4; e++) ep_or[e] = |ep_flags[e];
    msk_d = msk_q;
    if (hit(UDPAIR_OFF_IEN_SET) && pwrite) msk_d = msk_q | (pwdata[13:0] & UDPAIR_MASKABLE);
    if (hit(UDPAIR_OFF_IEN_CLR) && pwrite) msk_d = msk_q & ~pwdata[13:0];
    idle_d = bus_evt.bus_activity ? 0 : idle_q + 1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msk_q <= UDPAIR_MASK_RESET;
      idle_q <= 0;
    end else begin
      msk_q <= msk_d;
      idle_q <= idle_d;
    end
  end
  sequence addr_wr;
    hit(UDPAIR_OFF_FADDR) && pwrite;
  endsequence
  chk_addr_load: assert property (
    addr_wr |=> function_address_value == $past(pwdata[6:0])
      && function_enable == $past(pwdata[8])) else $error("address write lost");
  chk_addr_reset: assert property (
    $rose(presetn) |-> function_address_value == 7'h00) else $error("address not cleared");
  chk_xfer_gate: assert property (
    !function_enable [*2] |-> !ep_xfer_allow) else $error("transfer while disabled");
  chk_mask_read: assert property (
    hit(UDPAIR_OFF_IEN_STATE) && !pwrite |-> prdata == {18'h0, msk_q})
    else $error("mask readback wrong");
  chk_ep_status: assert property (
    hit(UDPAIR_OFF_IRQ_PEND) && !pwrite |-> prdata[3:0] == ep_or)
    else $error("endpoint status wrong");
  chk_irq_raise: assert property (
    |(ep_or & msk_q[3:0]) |-> irq) else $error("irq missing");
  chk_irq_quiet: assert property (
    msk_q == 14'h0000 |-> !irq) else $error("irq while all masked");
  chk_susp_due: assert property (
    idle_q == IDLE_SUSP_CYC + 2 |-> suspended) else $error("no suspend on idle bus");
  chk_susp_leave: assert property (
    suspended && bus_evt.bus_activity |-> ##[1:2] !suspended) else $error("stuck in suspend");
endmodule // udpair_regs_assertions

// ---- test/udpair_regs_test.sv ----
// Self-checking bench for udpair_regs: APB master, host model, mask model.
// Checker is bound at the foot of this file.
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module udpair_regs_test;
  import udpair_pkg::*;
  localparam int IDLE = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, func_en, xfer, susp, irq, quiet, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [6:0] fadr;
  logic [19:0] f;
  udpair_ep_flags_t [UDPAIR_NUM_EP-1:0] flg;
  udpair_bus_evt_t evt;
  int err_count, n_compared, cyc, seed, msk, stat;
  udpair_regs #(.IDLE_SUSP_CYC(IDLE)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ep_flags(flg), .bus_evt(evt),
    .function_address_value(fadr), .function_enable(func_en), .ep_xfer_allow(xfer),
    .suspended(susp), .irq(irq));
  udpair_host_model host (.pclk(pclk), .quiet(quiet), .bus_evt(evt));
  // ----------------------------------------
  // Bus tasks and model
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input int e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic wr(input logic [7:0] a, input int d);
    apb(1'b1, a, d);
    if (a == UDPAIR_OFF_IEN_SET) msk |= d & 32'h2F0F;
    if (a == UDPAIR_OFF_IEN_CLR) msk &= ~d;
    if (a == UDPAIR_OFF_IRQ_CLR) stat &= ~(d & 32'h3F00);
  endtask
  function automatic int epx(input logic [19:0] v);
    int r = 0;
    for (int e = 0; e < 4; e++) if (|v[e*5+:5]) r |= 1 << e;
    return r;
  endfunction
  task automatic wrap_up;
    $display("compared %0d, mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      wrap_up;
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 32'hD393B86C;
    {presetn, psel, penable, pwrite, quiet, paddr, pwdata, flg, f} = '0;
    {err_count, n_compared, cyc, stat} = '0;
    msk = 32'h200;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(UDPAIR_OFF_FADDR, 32'h0);
    rdchk(UDPAIR_OFF_IEN_STATE, 32'h200);
    host.pulse(1);
    stat = 32'h1000;
    rdchk(UDPAIR_OFF_IRQ_PEND, stat);
    `CHK(irq, 1'b0)
    wr(UDPAIR_OFF_FADDR, 32'h100);
    rdchk(UDPAIR_OFF_FADDR, 32'h100);
    `CHK(xfer, 1'b1)
    wr(UDPAIR_OFF_FADDR, 32'h15A);
    wr(UDPAIR_OFF_FADDR, 32'h5A);
    rdchk(UDPAIR_OFF_FADDR, 32'h5A);
    `CHK(xfer, 1'b0)
    for (int k = 0; k < 5; k++) begin
      if (k == 3) continue;
      host.pulse(k);
      stat |= 1 << (13 - k);
      rdchk(UDPAIR_OFF_IRQ_PEND, stat);
    end
    wr(UDPAIR_OFF_IRQ_CLR, 32'h3F00);
    repeat (12) begin
      wr(UDPAIR_OFF_IEN_SET, $random(seed));
      wr(UDPAIR_OFF_IEN_CLR, $random(seed) & $random(seed));
      f = $random(seed);
      flg <= f;
      rdchk(UDPAIR_OFF_IEN_STATE, msk);
      rdchk(UDPAIR_OFF_IRQ_PEND, stat | epx(f));
      `CHK(irq, |((stat | epx(f)) & msk))
    end
    wr(UDPAIR_OFF_IEN_CLR, 32'h3FFF);
    // Mask register takes the write at this edge; look once it has settled
    @(posedge pclk);
    `CHK(irq, 1'b0)
    `CHK(func_en, 1'b0)
    quiet <= 1'b1;
    repeat (IDLE + 6) @(posedge pclk);
    `CHK(susp, 1'b1)
    host.pulse(3);
    stat |= 32'h500;
    rdchk(UDPAIR_OFF_IRQ_PEND, stat | epx(f));
    quiet <= 1'b0;
    repeat (4) @(posedge pclk);
    `CHK(susp, 1'b0)
    rdchk(8'h80, 32'h0);
    `CHK(er, 1'b1)
    wrap_up;
  end
endmodule // udpair_regs_test
bind udpair_regs udpair_regs_assertions #(.IDLE_SUSP_CYC(IDLE_SUSP_CYC)) chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .ep_flags(ep_flags), .bus_evt(bus_evt),
  .function_address_value(function_address_value), .function_enable(function_enable),
  .ep_xfer_allow(ep_xfer_allow), .suspended(suspended), .irq(irq));
